// ==== pkg/i2cm_pkg.sv ====
// Package: addresses, field positions, reset values and timing for the bus master
package i2cm_pkg;

  // ==========================================================================
  // Special function register addresses
  localparam logic [15:0] SLAVE_ADDRESS_REG_ADDR = 16'hff80;
  localparam logic [15:0] WRITE_BYTE_REG_ADDR = 16'hff81;
  localparam logic [15:0] SECOND_WRITE_BYTE_REG_ADDR = 16'hff82;
  localparam logic [15:0] READ_BYTE_REG_ADDR = 16'hff83;
  localparam logic [15:0] SECOND_READ_BYTE_REG_ADDR = 16'hff84;
  localparam logic [15:0] BUS_CONTROL_STATUS_REG_ADDR = 16'hff85;
  localparam logic [15:0] EXT_INT6_CONTROL_ADDR = 16'hff95;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================================
  // Control/status field positions
  localparam int CSR_TWO_BYTE_SELECT_BIT = 0;
  localparam int CSR_START_BIT = 1;
  localparam int CSR_BUSY_BIT = 2;
  localparam int CSR_ADDR_NACK_BIT = 3;
  localparam int CSR_DATA_NACK_BIT = 4;

  // ==========================================================================
  // Interrupt-6 control field positions
  localparam int SUPPLY_FAULT_IRQ_EN_BIT = 5;
  localparam int SUPPLY_FAULT_FLAG_BIT = 4;
  localparam int BUS_DONE_IRQ_EN_BIT = 3;
  localparam int BUS_DONE_FLAG_BIT = 2;
  localparam int COMPARE_IRQ_EN_BIT = 1;
  localparam int COMPARE_FLAG_BIT = 0;

  // ==========================================================================
  // Slave address field layout
  localparam int DIRECTION_BIT = 0;

  // ==========================================================================
  // Serial timing
  localparam int SCL_RATE_KHZ = 400;
  localparam int TIME_BASE_PERIOD_NS = 125;
  localparam int QUARTERS_PER_BIT = 4;
  localparam int TB_EDGES_PER_QUARTER =
    1000000 / (SCL_RATE_KHZ * TIME_BASE_PERIOD_NS * QUARTERS_PER_BIT);
  localparam logic [2:0] TB_DIV_LAST = 3'(TB_EDGES_PER_QUARTER - 1);
  localparam logic [3:0] LAST_BIT_OF_BYTE = 4'h8;

  // ==========================================================================
  // Frame sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP
  } i2cm_state_type;

endpackage : i2cm_pkg

// ==== core/i2cm_time_base.sv ====
// Quarter-bit tick generator sampling the time-base clock
`timescale 1ns/100ps
`default_nettype none

module i2cm_time_base
  import i2cm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tb_clk,
  output var logic quarter_tick
);

  logic [2:0] tb_sync_r;
  logic [2:0] tb_sync_nxt;
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic tick_r;
  logic tick_nxt;
  logic tb_rise;

  // ==========================================================================
  // Next values
  always_comb begin
    tb_sync_nxt = {tb_sync_r[1:0], tb_clk};
    tb_rise = tb_sync_r[1] & ~tb_sync_r[2];
    div_nxt = div_r;
    tick_nxt = 1'b0;
    if (tb_rise) begin
      if (div_r == TB_DIV_LAST) begin
        div_nxt = 3'h0;
        tick_nxt = 1'b1;
      end else begin
        div_nxt = div_r + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tb_sync_r <= 3'h0;
      div_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      tb_sync_r <= tb_sync_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign quarter_tick = tick_r;

endmodule : i2cm_time_base

`default_nettype wire

// ==== core/i2cm_master.sv ====
// Byte-oriented serial bus master with interrupt-6 control register
// Notes on behaviour
// - Master only, serial clock at 400kHz.
// - Serial clock derived from time-base input.
// - Frames carry one or two data bytes.
// - Address register: 7-bit address plus direction.
// - First write byte sent first.
// - Length bit set sends second write byte.
// - Control bit 1 launches the transaction.
// - Read with length bit captures second byte.
// - Completion raises interrupt-6 flag and request.
// - Starting next transaction withdraws completion flag.
// - Control/status reports acknowledge errors.
// - Interrupt-6 register at 0xff95, resets 0x00.
// - Bit 5 fault enable, bit 4 flag.
// - Compare flag sets even when masked.
// - Compare flag read-only, cleared on read.
// - Address bits 7:1, direction bit 0.
// - Second write byte only when length set.
`timescale 1ns/100ps
`default_nettype none

module i2cm_master
  import i2cm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tb_clk,
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output var logic [7:0] sfr_rdata,
  input wire logic scl_i,
  output var logic scl_o,
  output var logic scl_oe,
  input wire logic sda_i,
  output var logic sda_o,
  output var logic sda_oe,
  input wire logic supply_fault_in,
  input wire logic ana_above,
  input wire logic cmp_enable,
  input wire logic cmp_on_change,
  input wire logic cmp_rise_pol,
  output var logic int6_req
);

  // ==========================================================================
  // Declarations
  logic quarter_tick;
  logic [3:0] sync1_r, sync2_r, sync3_r;
  logic scl_s, sda_s, fault_s, fault_d, ana_s, ana_d;

  logic [7:0] slave_address_reg_r, slave_address_reg_nxt;
  logic [7:0] write_byte_reg_r, write_byte_reg_nxt;
  logic [7:0] second_write_byte_reg_r, second_write_byte_reg_nxt;
  logic [7:0] read_byte_reg_r, read_byte_reg_nxt;
  logic [7:0] second_read_byte_reg_r, second_read_byte_reg_nxt;
  logic two_byte_select_r, two_byte_select_nxt;
  logic addr_nack_r, addr_nack_nxt;
  logic data_nack_r, data_nack_nxt;
  logic [5:0] int6_r, int6_nxt;
  logic [7:0] sfr_rdata_r, sfr_rdata_nxt;
  logic int6_req_r, int6_req_nxt;

  i2cm_state_type state_r, state_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [1:0] byte_idx_r, byte_idx_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic scl_oe_r, scl_oe_nxt;
  logic sda_oe_r, sda_oe_nxt;

  logic busy, is_read, start_req, cmp_trigger, fault_rise, int6_rd;
  logic [1:0] last_idx;
  logic [8:0] rx9;

  // ==========================================================================
  // Time base
  // time-base tick
  i2cm_time_base u_time_base (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tb_clk(tb_clk),
    .quarter_tick(quarter_tick)
  );

  // ==========================================================================
  // Input synchronisers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
      sync3_r <= 4'hf;
    end else begin
      sync1_r <= {scl_i, sda_i, supply_fault_in, ana_above};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign scl_s = sync2_r[3];
  assign sda_s = sync2_r[2];
  assign fault_s = sync2_r[1];
  assign fault_d = sync3_r[1];
  assign ana_s = sync2_r[0];
  assign ana_d = sync3_r[0];

  // ==========================================================================
  // Next-state logic
  always_comb begin
    slave_address_reg_nxt = slave_address_reg_r;
    write_byte_reg_nxt = write_byte_reg_r;
    second_write_byte_reg_nxt = second_write_byte_reg_r;
    read_byte_reg_nxt = read_byte_reg_r;
    second_read_byte_reg_nxt = second_read_byte_reg_r;
    two_byte_select_nxt = two_byte_select_r;
    addr_nack_nxt = addr_nack_r;
    data_nack_nxt = data_nack_r;
    int6_nxt = int6_r;
    sfr_rdata_nxt = sfr_rdata_r;
    state_nxt = state_r;
    phase_nxt = phase_r;
    bitcnt_nxt = bitcnt_r;
    byte_idx_nxt = byte_idx_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    busy = (state_r != ST_IDLE);
    is_read = slave_address_reg_r[DIRECTION_BIT];
    last_idx = two_byte_select_r ? 2'h2 : 2'h1;
    rx9 = {rx_r, sda_s};
    fault_rise = fault_s & ~fault_d;
    cmp_trigger = cmp_enable & (cmp_on_change ? (ana_s ^ ana_d) :
                  (cmp_rise_pol ? (ana_s & ~ana_d) : (~ana_s & ana_d)));
    int6_rd = sfr_rd && (sfr_addr == EXT_INT6_CONTROL_ADDR);
    start_req = sfr_wr && (sfr_addr == BUS_CONTROL_STATUS_REG_ADDR) &&
                sfr_wdata[CSR_START_BIT] && !busy;

    // Register writes
    if (sfr_wr) begin
      case (sfr_addr)
        SLAVE_ADDRESS_REG_ADDR: slave_address_reg_nxt = sfr_wdata;
        WRITE_BYTE_REG_ADDR: write_byte_reg_nxt = sfr_wdata;
        SECOND_WRITE_BYTE_REG_ADDR: second_write_byte_reg_nxt = sfr_wdata;
        BUS_CONTROL_STATUS_REG_ADDR: begin
          if (!busy) begin
            two_byte_select_nxt = sfr_wdata[CSR_TWO_BYTE_SELECT_BIT];
          end
        end
        EXT_INT6_CONTROL_ADDR: begin
          int6_nxt[SUPPLY_FAULT_IRQ_EN_BIT] = sfr_wdata[SUPPLY_FAULT_IRQ_EN_BIT];
          if (!sfr_wdata[SUPPLY_FAULT_FLAG_BIT]) begin
            int6_nxt[SUPPLY_FAULT_FLAG_BIT] = 1'b0;
          end
          int6_nxt[BUS_DONE_IRQ_EN_BIT] = sfr_wdata[BUS_DONE_IRQ_EN_BIT];
          int6_nxt[COMPARE_IRQ_EN_BIT] = sfr_wdata[COMPARE_IRQ_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    if (start_req) begin
      state_nxt = ST_START;
      phase_nxt = 2'h0;
      bitcnt_nxt = 4'h0;
      byte_idx_nxt = 2'h0;
      sh_nxt = {slave_address_reg_r, 1'b1};
      addr_nack_nxt = 1'b0;
      data_nack_nxt = 1'b0;
      int6_nxt[BUS_DONE_FLAG_BIT] = 1'b0;
    end

    if (quarter_tick) begin
      case (state_r)
        ST_START: begin
          phase_nxt = phase_r + 2'h1;
          if (phase_r == 2'h3) begin
            state_nxt = ST_BIT;
          end
        end
        ST_BIT: begin
          if (phase_r == 2'h2) begin
            if (scl_s) begin
              phase_nxt = 2'h3;
            end
          end else if (phase_r != 2'h3) begin
            phase_nxt = phase_r + 2'h1;
          end else begin
            phase_nxt = 2'h0;
            rx_nxt = rx9[7:0];
            if (bitcnt_r != LAST_BIT_OF_BYTE) begin
              bitcnt_nxt = bitcnt_r + 4'h1;
              sh_nxt = {sh_r[7:0], 1'b1};
            end else begin
              bitcnt_nxt = 4'h0;
              if (byte_idx_r == 2'h0 && rx9[0]) begin
                addr_nack_nxt = 1'b1;
                state_nxt = ST_STOP;
              end else if (byte_idx_r != 2'h0 && !is_read && rx9[0]) begin
                data_nack_nxt = 1'b1;
                state_nxt = ST_STOP;
              end else begin
                if (is_read && byte_idx_r == 2'h1) begin
                  read_byte_reg_nxt = rx9[8:1];
                end
                if (is_read && byte_idx_r == 2'h2) begin
                  second_read_byte_reg_nxt = rx9[8:1];
                end
                if (byte_idx_r == last_idx) begin
                  state_nxt = ST_STOP;
                end else begin
                  byte_idx_nxt = byte_idx_r + 2'h1;
                  if (is_read) begin
                    sh_nxt = {8'hff, (byte_idx_r + 2'h1 == last_idx)};
                  end else if (byte_idx_r == 2'h0) begin
                    sh_nxt = {write_byte_reg_r, 1'b1};
                  end else begin
                    sh_nxt = {second_write_byte_reg_r, 1'b1};
                  end
                end
              end
            end
          end
        end
        ST_STOP: begin
          if (phase_r != 2'h2 || scl_s) begin
            phase_nxt = phase_r + 2'h1;
          end
          if (phase_r == 2'h3) begin
            state_nxt = ST_IDLE;
            int6_nxt[BUS_DONE_FLAG_BIT] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Event flags: set wins over clear
    if (fault_rise) begin
      int6_nxt[SUPPLY_FAULT_FLAG_BIT] = 1'b1;
    end
    if (int6_rd) begin
      int6_nxt[COMPARE_FLAG_BIT] = 1'b0;
    end
    if (cmp_trigger) begin
      int6_nxt[COMPARE_FLAG_BIT] = 1'b1;
    end

    // Register reads
    if (sfr_rd) begin
      case (sfr_addr)
        SLAVE_ADDRESS_REG_ADDR: sfr_rdata_nxt = slave_address_reg_r;
        WRITE_BYTE_REG_ADDR: sfr_rdata_nxt = write_byte_reg_r;
        SECOND_WRITE_BYTE_REG_ADDR: sfr_rdata_nxt = second_write_byte_reg_r;
        READ_BYTE_REG_ADDR: sfr_rdata_nxt = read_byte_reg_r;
        SECOND_READ_BYTE_REG_ADDR: sfr_rdata_nxt = second_read_byte_reg_r;
        BUS_CONTROL_STATUS_REG_ADDR: sfr_rdata_nxt = {3'h0, data_nack_r, addr_nack_r,
                                                     busy, 1'b0, two_byte_select_r};
        EXT_INT6_CONTROL_ADDR: sfr_rdata_nxt = {2'h0, int6_r};
        default: sfr_rdata_nxt = BYTE_RESET;
      endcase
    end

    int6_req_nxt = (int6_nxt[SUPPLY_FAULT_FLAG_BIT] & int6_nxt[SUPPLY_FAULT_IRQ_EN_BIT]) |
                   (int6_nxt[BUS_DONE_FLAG_BIT] & int6_nxt[BUS_DONE_IRQ_EN_BIT]) |
                   (int6_nxt[COMPARE_FLAG_BIT] & int6_nxt[COMPARE_IRQ_EN_BIT]);

    scl_oe_nxt = 1'b0;
    sda_oe_nxt = 1'b0;
    case (state_nxt)
      ST_START: sda_oe_nxt = (phase_nxt >= 2'h2);
      ST_BIT: begin
        scl_oe_nxt = (phase_nxt < 2'h2);
        sda_oe_nxt = (phase_nxt == 2'h0) ? sda_oe_r : ~sh_nxt[8];
      end
      ST_STOP: begin
        scl_oe_nxt = (phase_nxt < 2'h2);
        sda_oe_nxt = (phase_nxt == 2'h0) ? sda_oe_r : (phase_nxt != 2'h3);
      end
      default: begin
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slave_address_reg_r <= BYTE_RESET;
      write_byte_reg_r <= BYTE_RESET;
      second_write_byte_reg_r <= BYTE_RESET;
      read_byte_reg_r <= BYTE_RESET;
      second_read_byte_reg_r <= BYTE_RESET;
      two_byte_select_r <= 1'b0;
      addr_nack_r <= 1'b0;
      data_nack_r <= 1'b0;
      int6_r <= 6'h00;
      sfr_rdata_r <= BYTE_RESET;
      int6_req_r <= 1'b0;
      state_r <= ST_IDLE;
      phase_r <= 2'h0;
      bitcnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      sh_r <= 9'h1ff;
      rx_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      slave_address_reg_r <= slave_address_reg_nxt;
      write_byte_reg_r <= write_byte_reg_nxt;
      second_write_byte_reg_r <= second_write_byte_reg_nxt;
      read_byte_reg_r <= read_byte_reg_nxt;
      second_read_byte_reg_r <= second_read_byte_reg_nxt;
      two_byte_select_r <= two_byte_select_nxt;
      addr_nack_r <= addr_nack_nxt;
      data_nack_r <= data_nack_nxt;
      int6_r <= int6_nxt;
      sfr_rdata_r <= sfr_rdata_nxt;
      int6_req_r <= int6_req_nxt;
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      bitcnt_r <= bitcnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // Open-drain: the driven level is always low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign sfr_rdata = sfr_rdata_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign int6_req = int6_req_r;

endmodule : i2cm_master

`default_nettype wire

// ==== verification/i2cm_master_asserts.sv ====
// Concurrent checks on the bus master ports
`timescale 1ns/100ps
`default_nettype none

module i2cm_master_asserts
  import i2cm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic ana_above,
  input wire logic int6_req
);
  logic frame_r, frame_nxt, sda_oe_r;
  logic [7:0] low_cnt_r, low_cnt_nxt;
  logic rd_int6;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Frame tracking from start and stop conditions
  assign rd_int6 = sfr_rd && sfr_addr == EXT_INT6_CONTROL_ADDR;
  always_comb begin
    frame_nxt = (!scl_oe && sda_oe != sda_oe_r) ? sda_oe : frame_r;
    low_cnt_nxt = scl_oe ? low_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      frame_r <= 1'b0;
      sda_oe_r <= 1'b0;
      low_cnt_r <= 8'h00;
    end else begin
      frame_r <= frame_nxt;
      sda_oe_r <= sda_oe;
      low_cnt_r <= low_cnt_nxt;
    end
  end

  // ==========================================================================
  // Properties
  // lines only pulled low
  AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("bus line driven high");
  AST_SCL_LOW_TIME: assert property ($fell(scl_oe) |-> low_cnt_r inside {[8'h7a:8'h80]})
    else $error("clock low time off");
  AST_SDA_AT_RELEASE: assert property ($fell(scl_oe) |-> $stable(sda_oe))
    else $error("data moved with clock release");
  AST_IDLE_QUIET: assert property ($rose(scl_oe) |-> frame_r)
    else $error("clock pulled outside a frame");
  AST_START_LAUNCH: assert property (sfr_wr && sfr_addr == BUS_CONTROL_STATUS_REG_ADDR
    && sfr_wdata[CSR_START_BIT] && !frame_r && !scl_oe |-> ##[1:300] (sda_oe && !scl_oe))
    else $error("no start condition after launch");
  AST_INT6_RSVD: assert property (rd_int6 |=> sfr_rdata[7:6] == 2'b00)
    else $error("reserved bits set");
  AST_REQ_OR: assert property (rd_int6 |=> $past(int6_req) == ((sfr_rdata[5] & sfr_rdata[4])
    | (sfr_rdata[3] & sfr_rdata[2]) | (sfr_rdata[1] & sfr_rdata[0])))
    else $error("request differs from enabled flags");
  AST_CSR_READ: assert property (sfr_rd && sfr_addr == BUS_CONTROL_STATUS_REG_ADDR
    |=> sfr_rdata[7:5] == 3'h0 && !sfr_rdata[CSR_START_BIT])
    else $error("control read shows start or spare bits");
  AST_CMP_CLEAR: assert property (($stable(ana_above) [*6] ##0 rd_int6 ##1 $stable(ana_above)
    ##1 ($stable(ana_above) && rd_int6)) |=> !sfr_rdata[COMPARE_FLAG_BIT])
    else $error("compare flag survived a read");
endmodule : i2cm_master_asserts

bind i2cm_master i2cm_master_asserts u_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
  .ana_above(ana_above), .int6_req(int6_req));
`default_nettype wire

// ==== verification/i2cm_slave_model.sv ====
// Behavioural slave on the serial bus
`timescale 1ns/100ps
`default_nettype none

module i2cm_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  input wire logic nack_wr,
  input wire logic [7:0] rd_byte0,
  input wire logic [7:0] rd_byte1,
  output var logic scl_oe = 1'b0,
  output var logic sda_oe = 1'b0,
  output var logic [7:0] got_byte = 8'h00,
  output var logic got_stb = 1'b0
);
  logic act = 1'b0;
  logic mute, rd;
  logic [7:0] sh, cur;
  int bitn, byten;
  assign cur = byten == 1 ? rd_byte0 : rd_byte1;

  // ==========================================================================
  // Start and stop conditions
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    mute = 1'b0;
    bitn = -1;
    byten = 0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;

  // ==========================================================================
  // sampling and acknowledge per byte
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (rd && byten > 0 && sda) mute = 1'b1;
  end
  always @(negedge scl) if (act) begin
    bitn = bitn + 1;
    if (bitn == 9) begin
      bitn = 0;
      byten = byten + 1;
    end
    if (bitn == 8 && byten == 0) begin
      rd = sh[0];
      mute = sh[7:1] != OWN_ADDR;
    end
    if (bitn == 8 && byten > 0 && !rd) begin
      mute = mute || nack_wr;
      got_byte = sh;
      got_stb = 1'b1;
    end
    sda_oe = !mute && (bitn == 8 ? (byten == 0 || !rd) : (rd && byten > 0 && !cur[7 - bitn]));
    #1;
    got_stb = 1'b0;
    if (slow && !mute) begin
      scl_oe = 1'b1;
      #2000;
      scl_oe = 1'b0;
    end
  end
endmodule : i2cm_slave_model
`default_nettype wire

// ==== verification/tb_i2c_master_with_int6_control.sv ====
// Self-checking bench for the serial bus master
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module tb_i2c_master_with_int6_control
  import i2cm_pkg::*;
;
  localparam logic [6:0] SLV = 7'h2a;
  logic clk_sys = 1'b0, reset_n = 1'b0, tb_clk = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic [7:0] sfr_wdata = 8'h00, sfr_rdata, got_byte, d0, d1, exp_r, exp_w;
  logic [7:0] rd0 = 8'h00, rd1 = 8'h00;
  logic scl_o, scl_oe, sda_o, sda_oe, int6_req, s_scl_oe, s_sda_oe, got_stb, scl, sda;
  logic supply_fault_in = 1'b0, ana_above = 1'b0, cmp_enable = 1'b0, cmp_on_change = 1'b0;
  logic slow = 1'b0, nack_wr = 1'b0, rd_d = 1'b0, cmp_rise_pol = 1'b0;
  logic [7:0] wr_q[$], rd_q[$];
  logic [31:0] seed = 32'h00000031;
  logic [15:0] addrs[8] = '{SLAVE_ADDRESS_REG_ADDR, WRITE_BYTE_REG_ADDR,
    SECOND_WRITE_BYTE_REG_ADDR, READ_BYTE_REG_ADDR, SECOND_READ_BYTE_REG_ADDR,
    BUS_CONTROL_STATUS_REG_ADDR, EXT_INT6_CONTROL_ADDR, 16'hff86};
  int fails = 0, cmp_count = 0;

  always #5 clk_sys = ~clk_sys;
  initial #3.3 forever #62.5 tb_clk = ~tb_clk;
  assign scl = !(scl_oe | s_scl_oe);
  assign sda = !(sda_oe | s_sda_oe);

  i2cm_master u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .tb_clk(tb_clk),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .supply_fault_in(supply_fault_in),
    .ana_above(ana_above), .cmp_enable(cmp_enable), .cmp_on_change(cmp_on_change),
    .cmp_rise_pol(cmp_rise_pol), .int6_req(int6_req));
  i2cm_slave_model #(.OWN_ADDR(SLV)) u_slave (.scl(scl), .sda(sda), .slow(slow),
    .nack_wr(nack_wr), .rd_byte0(rd0), .rd_byte1(rd1), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe), .got_byte(got_byte), .got_stb(got_stb));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  // Program, launch, wait for completion, check status
  task automatic run(input logic [7:0] slave_address_reg, input logic [7:0] bus_control_status_reg, input logic [7:0] csr_e);
    int n;
    wr(SLAVE_ADDRESS_REG_ADDR, slave_address_reg);
    wr(BUS_CONTROL_STATUS_REG_ADDR, bus_control_status_reg & 8'h01);
    wr(BUS_CONTROL_STATUS_REG_ADDR, bus_control_status_reg);
    rd(EXT_INT6_CONTROL_ADDR, 8'h08);
    n = 0;
    while (int6_req !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n < 20000, 1'b1)
    rd(BUS_CONTROL_STATUS_REG_ADDR, csr_e);
    rd(EXT_INT6_CONTROL_ADDR, 8'h0c);
    `CHK(wr_q.size(), 0)
  endtask : run

  // ==========================================================================
  // Result monitors
  always @(posedge clk_sys) begin
    if (rd_d) begin
      exp_r = rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx;
      `CHK(sfr_rdata, exp_r)
    end
    rd_d <= sfr_rd;
  end
  always @(posedge got_stb) begin
    exp_w = wr_q.size() > 0 ? wr_q.pop_front() : 8'hxx;
    `CHK(got_byte, exp_w)
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    test_done();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    wr(EXT_INT6_CONTROL_ADDR, 8'hff);
    rd(EXT_INT6_CONTROL_ADDR, 8'h2a);
    wr(EXT_INT6_CONTROL_ADDR, 8'h08);
    d0 = rnd();
    wr_q.push_back(d0);
    wr(WRITE_BYTE_REG_ADDR, d0);
    wr(SECOND_WRITE_BYTE_REG_ADDR, rnd());
    run({SLV, 1'b0}, 8'h02, 8'h00);
    d0 = rnd();
    d1 = rnd();
    wr_q.push_back(d0);
    wr_q.push_back(d1);
    wr(WRITE_BYTE_REG_ADDR, d0);
    wr(SECOND_WRITE_BYTE_REG_ADDR, d1);
    slow <= 1'b1;
    run({SLV, 1'b0}, 8'h03, 8'h01);
    slow <= 1'b0;
    for (int n = 1; n <= 2; n++) begin
      d0 = rnd();
      d1 = rnd();
      rd0 <= d0;
      rd1 <= d1;
      run({SLV, 1'b1}, 8'(n + 1), 8'(n - 1));
      rd(READ_BYTE_REG_ADDR, d0);
      if (n == 2) rd(SECOND_READ_BYTE_REG_ADDR, d1);
    end
    run({SLV ^ 7'h01, 1'b0}, 8'h02, 8'h08);
    d0 = rnd();
    wr_q.push_back(d0);
    wr(WRITE_BYTE_REG_ADDR, d0);
    nack_wr <= 1'b1;
    run({SLV, 1'b0}, 8'h02, 8'h10);
    nack_wr <= 1'b0;
    wr(EXT_INT6_CONTROL_ADDR, 8'h28);
    supply_fault_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(EXT_INT6_CONTROL_ADDR, 8'h3c);
    supply_fault_in <= 1'b0;
    wr(EXT_INT6_CONTROL_ADDR, 8'h08);
    rd(EXT_INT6_CONTROL_ADDR, 8'h0c);
    wr(EXT_INT6_CONTROL_ADDR, 8'h00);
    cmp_enable <= 1'b1;
    cmp_on_change <= 1'b1;
    @(posedge clk_sys);
    ana_above <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(EXT_INT6_CONTROL_ADDR, 8'h05);
    rd(EXT_INT6_CONTROL_ADDR, 8'h04);
    cmp_on_change <= 1'b0;
    ana_above <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(EXT_INT6_CONTROL_ADDR, 8'h05);
    cmp_rise_pol <= 1'b1;
    @(posedge clk_sys);
    ana_above <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(EXT_INT6_CONTROL_ADDR, 8'h05);
    ana_above <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(EXT_INT6_CONTROL_ADDR, 8'h04);
    test_done();
  end
endmodule : tb_i2c_master_with_int6_control
`default_nettype wire
